//--- caw_pkg.sv
// Purpose: shared constants and types for the counter array with supervisory timer
// Assumes: 16-bit register port, six channels
// Notes:   offsets are word addresses on the plain register port
package caw_pkg;
	localparam int          NUM_CH         = 6;
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_COUNT      = 8'h01;
	localparam logic [7:0]  OFS_IRQ_STAT   = 8'h02;
	localparam logic [7:0]  OFS_IRQ_CLR    = 8'h03;
	localparam logic [7:0]  OFS_IRQ_EN     = 8'h04;
	localparam logic [7:0]  OFS_WD_CTRL    = 8'h05;
	localparam logic [7:0]  OFS_WD_RESTART = 8'h06;
	localparam logic [7:0]  OFS_CH_BASE    = 8'h10;
	localparam int          CTRL_RUN_BIT   = 0;
	localparam int          CTRL_SRC_BIT   = 1;
	localparam int          CTRL_DIV_LSB   = 8;
	localparam int          WD_EN_BIT      = 0;
	localparam int          WD_LIM_LSB     = 8;
	localparam int          IRQ_OVF_BIT    = 0;
	localparam int          IRQ_CH_LSB     = 1;
	localparam logic [15:0] CTRL_RST       = 16'h0000;
	localparam logic [15:0] WD_CTRL_RST    = 16'hFF01;
	localparam logic [7:0]  WD_LSB_TOP     = 8'hFF;

	typedef enum logic [2:0] {
		CAW_OFF   = 3'h0,
		CAW_CAPT  = 3'h1,
		CAW_SWTMR = 3'h3,
		CAW_HSO   = 3'h2,
		CAW_FREQ  = 3'h6,
		CAW_PWM   = 3'h7
	} caw_mode_e;

	typedef enum logic [1:0] {
		WD_RUN  = 2'h0,
		WD_FIRE = 2'h1,
		WD_OFF  = 2'h3
	} caw_wd_e;

	// channel config word: [2:0] mode, [4:3] edge (bit3 rise, bit4 fall), [7:5] pwm res, [8] line enable
	typedef struct packed {
		logic       oe;
		logic [2:0] res;
		logic [1:0] edge_sel;
		caw_mode_e  mode;
	} caw_ch_cfg_s;

	typedef struct packed {
		logic        evt;
		logic        line;
		logic        oe;
		logic [15:0] value;
	} caw_ch_stat_s;
endpackage : caw_pkg

//--- caw_tick_gen.sv
// Purpose: timebase count enable from divided clock or external edges
// Assumes: ext_clk_in is synchronous to clk
// Notes:   one-cycle tick pulse
`timescale 1ns/10ps
`default_nettype none
module caw_tick_gen
	import caw_pkg::*;
#(
	parameter int DIV_W = 8
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             run,
	input  wire logic             src_ext,
	input  wire logic [DIV_W-1:0] divisor,
	input  wire logic             ext_in,
	output logic                  tick
);
	logic [DIV_W-1:0] cnt_reg, cnt_next;
	logic             prev_reg, tick_next;

	always_comb begin
		cnt_next  = cnt_reg;
		tick_next = 1'b0;
		if (!run) begin
			cnt_next = '0;
		end else if (src_ext) begin
			tick_next = ext_in & ~prev_reg;
		end else if (cnt_reg >= divisor) begin
			// divisor n gives one tick every n+1 clocks
			cnt_next  = '0;
			tick_next = 1'b1;
		end else begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg  <= '0;
			prev_reg <= 1'b0;
			tick     <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			prev_reg <= ext_in;
			tick     <= tick_next;
		end
	end
endmodule : caw_tick_gen
`default_nettype wire

//--- caw_channel.sv
// Purpose: one capture/compare channel
// Assumes: line_in synchronous to clk; tick marks a timebase step
// Notes:   compare uses the count value present with the tick
`timescale 1ns/10ps
`default_nettype none
module caw_channel
	import caw_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         tick,
	input  wire logic [15:0]  base,
	input  wire caw_ch_cfg_s  cfg,
	input  wire logic         wr_val,
	input  wire logic [15:0]  wdata,
	input  wire logic         line_in,
	output caw_ch_stat_s      stat
);
	logic [15:0]  mask, mb, mv;
	logic         prev_reg, rise, fall;
	caw_ch_stat_s stat_next;

	always_comb begin
		case (cfg.res)
			3'h0:    mask = 16'h00FF;
			3'h1:    mask = 16'h01FF;
			3'h2:    mask = 16'h03FF;
			3'h3:    mask = 16'h07FF;
			default: mask = 16'hFFFF;
		endcase
		mb        = base & mask;
		mv        = stat.value & mask;
		rise      = line_in & ~prev_reg;
		fall      = ~line_in & prev_reg;
		stat_next = stat;
		stat_next.evt = 1'b0;
		case (cfg.mode)
			CAW_CAPT: begin
				if ((rise & cfg.edge_sel[0]) | (fall & cfg.edge_sel[1])) begin
					stat_next.value = base;
					stat_next.evt   = 1'b1;
				end
			end
			CAW_SWTMR: begin
				stat_next.evt = tick && base == stat.value;
			end
			CAW_HSO: begin
				if (tick && base == stat.value) begin
					stat_next.evt  = 1'b1;
					stat_next.line = ~stat.line;
				end
			end
			CAW_FREQ: begin
				// low byte is next match, high byte is half period
				if (tick && base[7:0] == stat.value[7:0]) begin
					stat_next.evt        = 1'b1;
					stat_next.line       = ~stat.line;
					stat_next.value[7:0] = stat.value[7:0] + stat.value[15:8];
				end
			end
			CAW_PWM: begin
				stat_next.line = mb < mv;
				stat_next.evt  = tick && mb == 16'h0000;
			end
			default: stat_next.line = 1'b0;
		endcase
		if (wr_val) begin
			stat_next.value = wdata;
		end
		stat_next.oe = cfg.oe && (cfg.mode == CAW_HSO || cfg.mode == CAW_FREQ || cfg.mode == CAW_PWM);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_reg <= 1'b0;
			stat     <= '0;
		end else begin
			prev_reg <= line_in;
			stat     <= stat_next;
		end
	end

	chk_capture_value: assert property (@(posedge clk) disable iff (!arst_n)
		(cfg.mode == CAW_CAPT && line_in && !prev_reg && cfg.edge_sel[0] && !wr_val)
		|=> (stat.evt && stat.value == $past(base)))
		else $error("capture missed rising edge");
	chk_hso_toggle: assert property (@(posedge clk) disable iff (!arst_n)
		(cfg.mode == CAW_HSO && tick && base == stat.value && $stable(cfg)) |=> (stat.line != $past(stat.line)))
		else $error("hso did not toggle on match");
	chk_line_gate: assert property (@(posedge clk) disable iff (!arst_n)
		(!cfg.oe || cfg.mode == CAW_CAPT) |=> !stat.oe)
		else $error("line driven while disabled");
endmodule : caw_channel
`default_nettype wire

//--- caw_core.sv
// Purpose: counter array with six capture/compare channels and a supervisory timer
// Assumes: plain register port, reads answer one cycle after the strobe
// Notes:   wd_reset_req is held until the system applies arst_n
`timescale 1ns/10ps
`default_nettype none
module caw_core
	import caw_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [15:0]            reg_rdata,
	input  wire logic              ext_clk_in,
	input  wire logic [NUM_CH-1:0] channel_io_line_in,
	output logic [NUM_CH-1:0]      channel_io_line_out,
	output logic [NUM_CH-1:0]      channel_io_line_oe,
	output logic                   irq,
	output logic                   wd_reset_req,
	output logic                   reset_pin_n_out,
	output logic                   reset_pin_n_oe
);
	localparam int NIRQ = NUM_CH + 1;

	logic [15:0]       ctrl_reg, ctrl_next;
	logic [15:0]       count_reg, count_next;
	logic [NIRQ-1:0]   stat_reg, stat_next, en_reg, en_next;
	logic [15:0]       wd_ctrl_reg, wd_ctrl_next;
	logic [15:0]       wd_cnt_reg, wd_cnt_next;
	caw_wd_e           wd_st_reg, wd_st_next;
	logic [15:0]       rdata_next;
	logic              irq_next, tick, ovf, wd_restart;
	logic [NIRQ-1:0]   evt_set, clr;
	caw_ch_cfg_s       ch_cfg_reg [NUM_CH];
	caw_ch_cfg_s       ch_cfg_next [NUM_CH];
	caw_ch_stat_s      ch_stat [NUM_CH];
	logic [NUM_CH-1:0] ch_val_wr;

	caw_tick_gen #(
		.DIV_W (8)
	) u_tick (
		.clk     (clk),
		.arst_n  (arst_n),
		.run     (ctrl_reg[CTRL_RUN_BIT]),
		.src_ext (ctrl_reg[CTRL_SRC_BIT]),
		.divisor (ctrl_reg[CTRL_DIV_LSB +: 8]),
		.ext_in  (ext_clk_in),
		.tick    (tick)
	);

	// address decode for channel words: even offset is config, odd is value
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			ch_cfg_next[i] = ch_cfg_reg[i];
			ch_val_wr[i]   = 1'b0;
			if (reg_wr && reg_addr == OFS_CH_BASE + 8'(2 * i)) begin
				ch_cfg_next[i] = caw_ch_cfg_s'(reg_wdata[8:0]);
			end else if (reg_wr && reg_addr == OFS_CH_BASE + 8'(2 * i + 1)) begin
				ch_val_wr[i] = 1'b1;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gen_ch
			caw_channel u_ch (
				.clk     (clk),
				.arst_n  (arst_n),
				.tick    (tick),
				.base    (count_reg),
				.cfg     (ch_cfg_reg[g]),
				.wr_val  (ch_val_wr[g]),
				.wdata   (reg_wdata),
				.line_in (channel_io_line_in[g]),
				.stat    (ch_stat[g])
			);
			assign evt_set[IRQ_CH_LSB + g]    = ch_stat[g].evt;
			assign channel_io_line_out[g]     = ch_stat[g].line;
			assign channel_io_line_oe[g]      = ch_stat[g].oe;
		end
	endgenerate

	assign ovf                  = tick && count_reg == 16'hFFFF;
	assign evt_set[IRQ_OVF_BIT] = ovf;
	assign wd_restart           = reg_wr && reg_addr == OFS_WD_RESTART;

	// timebase, control, interrupt registers
	always_comb begin
		ctrl_next  = ctrl_reg;
		count_next = count_reg;
		en_next    = en_reg;
		clr        = '0;
		if (tick) begin
			count_next = count_reg + 16'h0001;
		end
		if (reg_wr) begin
			if (reg_addr == OFS_CTRL) begin
				ctrl_next = reg_wdata;
			end else if (reg_addr == OFS_COUNT) begin
				count_next = reg_wdata;
			end else if (reg_addr == OFS_IRQ_CLR) begin
				clr = reg_wdata[NIRQ-1:0];
			end else if (reg_addr == OFS_IRQ_EN) begin
				en_next = reg_wdata[NIRQ-1:0];
			end
		end
		// a new event beats a clear in the same cycle
		stat_next = (stat_reg & ~clr) | evt_set;
		irq_next  = |(stat_next & en_next);
	end

	// supervisory timer
	always_comb begin
		wd_ctrl_next = wd_ctrl_reg;
		wd_cnt_next  = wd_cnt_reg;
		wd_st_next   = wd_st_reg;
		if (reg_wr && reg_addr == OFS_WD_CTRL && wd_st_reg != WD_FIRE) begin
			wd_ctrl_next = reg_wdata;
		end
		case (wd_st_reg)
			WD_RUN: begin
				if (!wd_ctrl_reg[WD_EN_BIT]) begin
					wd_st_next  = WD_OFF;
					wd_cnt_next = '0;
				end else if (wd_restart) begin
					wd_cnt_next = '0;
				end else if (tick) begin
					if (wd_cnt_reg == {wd_ctrl_reg[WD_LIM_LSB +: 8], WD_LSB_TOP}) begin
						wd_st_next = WD_FIRE;
					end else begin
						wd_cnt_next = wd_cnt_reg + 16'h0001;
					end
				end
			end
			WD_OFF: begin
				if (wd_ctrl_reg[WD_EN_BIT]) begin
					wd_st_next = WD_RUN;
				end
			end
			// held until the device reset arrives
			default: wd_st_next = WD_FIRE;
		endcase
	end

	// read mux, unmapped addresses read zero
	always_comb begin
		rdata_next = 16'h0000;
		if (reg_addr == OFS_CTRL) begin
			rdata_next = ctrl_reg;
		end else if (reg_addr == OFS_COUNT) begin
			rdata_next = count_reg;
		end else if (reg_addr == OFS_IRQ_STAT) begin
			rdata_next = 16'(stat_reg);
		end else if (reg_addr == OFS_IRQ_EN) begin
			rdata_next = 16'(en_reg);
		end else if (reg_addr == OFS_WD_CTRL) begin
			rdata_next = wd_ctrl_reg;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (reg_addr == OFS_CH_BASE + 8'(2 * i)) begin
					rdata_next = 16'(ch_cfg_reg[i]);
				end else if (reg_addr == OFS_CH_BASE + 8'(2 * i + 1)) begin
					rdata_next = ch_stat[i].value;
				end
			end
		end
		if (!reg_rd) begin
			rdata_next = 16'h0000;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg        <= CTRL_RST;
			count_reg       <= '0;
			stat_reg        <= '0;
			en_reg          <= '0;
			irq             <= 1'b0;
			wd_ctrl_reg     <= WD_CTRL_RST;
			wd_cnt_reg      <= '0;
			wd_st_reg       <= WD_RUN;
			wd_reset_req    <= 1'b0;
			reset_pin_n_out <= 1'b1;
			reset_pin_n_oe  <= 1'b0;
			reg_rdata       <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				ch_cfg_reg[i] <= '0;
			end
		end else begin
			ctrl_reg        <= ctrl_next;
			count_reg       <= count_next;
			stat_reg        <= stat_next;
			en_reg          <= en_next;
			irq             <= irq_next;
			wd_ctrl_reg     <= wd_ctrl_next;
			wd_cnt_reg      <= wd_cnt_next;
			wd_st_reg       <= wd_st_next;
			wd_reset_req    <= wd_st_next == WD_FIRE;
			// the reset pin is never driven from here
			reset_pin_n_out <= 1'b1;
			reset_pin_n_oe  <= 1'b0;
			reg_rdata       <= rdata_next;
			ch_cfg_reg      <= ch_cfg_next;
		end
	end

	chk_ovf_sets_flag: assert property (@(posedge clk) disable iff (!arst_n)
		ovf |=> (stat_reg[IRQ_OVF_BIT] && count_reg == 16'h0000) || $past(reg_wr))
		else $error("rollover did not set flag");
	chk_irq_level: assert property (@(posedge clk) disable iff (!arst_n)
		##1 irq == |($past(stat_next) & $past(en_next)))
		else $error("irq does not follow enabled status");
	chk_wd_fire: assert property (@(posedge clk) disable iff (!arst_n)
		(wd_st_reg == WD_RUN && wd_ctrl_reg[WD_EN_BIT] && !wd_restart && tick
		 && wd_cnt_reg == {wd_ctrl_reg[WD_LIM_LSB +: 8], WD_LSB_TOP}) |=> wd_reset_req ##1 wd_reset_req)
		else $error("supervisory overflow gave no reset");
	chk_wd_restart: assert property (@(posedge clk) disable iff (!arst_n)
		(wd_st_reg == WD_RUN && wd_ctrl_reg[WD_EN_BIT] && wd_restart) |=> wd_cnt_reg == 16'h0000)
		else $error("restart did not clear timer");
	chk_wd_off_quiet: assert property (@(posedge clk) disable iff (!arst_n)
		(wd_st_reg == WD_OFF) |-> !wd_reset_req)
		else $error("disabled timer fired");
	chk_pin_undriven: assert property (@(posedge clk) disable iff (!arst_n)
		wd_reset_req |-> !reset_pin_n_oe)
		else $error("reset pin driven");
	chk_read_zero: assert property (@(posedge clk) disable iff (!arst_n)
		!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data outside answer cycle");
endmodule : caw_core
`default_nettype wire

//--- caw_pin_model.sv
// Purpose: far side of the channel pins
// Assumes: one clock; bench sets which lines it drives
// Notes:   a released line toggles each cycle so a stale level never shows
`timescale 1ns/10ps
`default_nettype none
module caw_pin_model
	import caw_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [NUM_CH-1:0] line_out,
	input  wire logic [NUM_CH-1:0] line_oe,
	input  wire logic [NUM_CH-1:0] drv_en,
	input  wire logic [NUM_CH-1:0] drv_val,
	output logic      [NUM_CH-1:0] pin
);
	logic [NUM_CH-1:0] float_reg = '0;
	always_ff @(posedge clk) begin
		float_reg <= ~float_reg;
	end
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			pin[i] = line_oe[i] ? line_out[i] : (drv_en[i] ? drv_val[i] : float_reg[i]);
		end
	end
endmodule : caw_pin_model
`default_nettype wire

//--- tb.sv
// Purpose: self-checking bench for the counter array core
// Assumes: reads answer in the cycle after the strobe
// Notes:   expected read values are queued and compared by a monitor
`timescale 1ns/10ps
`default_nettype none
module tb;
	import caw_pkg::*;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic        ext_clk_in = 1'b0;
	logic [5:0]  pin, l_out, l_oe;
	logic [5:0]  drv_en = 6'h00;
	logic [5:0]  drv_val = 6'h00;
	logic        irq, wd_req, rp_out, rp_oe;
	logic        rd_pend = 1'b0;
	logic [15:0] exp_q[$];
	int          miscompares = 0;
	int          n_tests = 0;
	int          cyc = 0;
	initial begin
		forever #2 clk = ~clk;
	end
	caw_core dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_in(ext_clk_in), .channel_io_line_in(pin),
		.channel_io_line_out(l_out), .channel_io_line_oe(l_oe), .irq(irq), .wd_reset_req(wd_req),
		.reset_pin_n_out(rp_out), .reset_pin_n_oe(rp_oe));
	caw_pin_model pins (.clk(clk), .line_out(l_out), .line_oe(l_oe), .drv_en(drv_en), .drv_val(drv_val),
		.pin(pin));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : rd
	task automatic cyc_wait(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc_wait
	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done
	always @(posedge clk) begin
		rd_pend <= reg_rd;
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	always @(negedge clk) begin
		if (rd_pend)
			check(reg_rdata, exp_q.pop_front());
	end
	initial begin
		logic [15:0] v, v2, hi;
		logic [1:0]  es;
		caw_ch_cfg_s c;
		void'($urandom(32'he845));
		cyc_wait(4);
		arst_n <= 1'b1;
		rd(OFS_CTRL, CTRL_RST);
		rd(OFS_WD_CTRL, WD_CTRL_RST);
		rd(OFS_IRQ_EN, 16'h0000);
		rd(8'h3F, 16'h0000);
		check({15'h0, rp_oe}, 16'h0000);
		wr(OFS_WD_CTRL, 16'h0000);
		done("reset");
		wr(OFS_COUNT, 16'h0000);
		wr(OFS_CTRL, 16'h0003);
		repeat (5) begin
			@(posedge clk);
			ext_clk_in <= 1'b1;
			@(posedge clk);
			ext_clk_in <= 1'b0;
		end
		cyc_wait(4);
		wr(OFS_CTRL, 16'h0000);
		rd(OFS_COUNT, 16'h0005);
		done("ext source");
		drv_en <= 6'h3F;
		for (int i = 0; i < NUM_CH; i++) begin
			es = 2'(i % 3 + 1);
			v = 16'($urandom);
			c = '{oe: 1'b0, res: 3'h0, edge_sel: es, mode: CAW_CAPT};
			wr(OFS_COUNT, v);
			wr(8'(OFS_CH_BASE + 2 * i + 1), 16'h0000);
			wr(8'(OFS_CH_BASE + 2 * i), 16'(c));
			drv_val[i] <= 1'b1;
			cyc_wait(3);
			rd(8'(OFS_CH_BASE + 2 * i + 1), es[0] ? v : 16'h0000);
			v2 = 16'($urandom);
			wr(OFS_COUNT, v2);
			drv_val[i] <= 1'b0;
			cyc_wait(3);
			rd(8'(OFS_CH_BASE + 2 * i + 1), es[1] ? v2 : (es[0] ? v : 16'h0000));
			wr(8'(OFS_CH_BASE + 2 * i), 16'h0000);
		end
		rd(OFS_IRQ_STAT, 16'h007E);
		drv_en <= 6'h00;
		done("capture");
		wr(OFS_IRQ_CLR, 16'h007F);
		wr(OFS_IRQ_EN, 16'h0001);
		wr(OFS_COUNT, 16'hFFFE);
		wr(OFS_CTRL, 16'h0001);
		cyc_wait(3);
		wr(OFS_CTRL, 16'h0000);
		cyc_wait(2);
		check({15'h0, irq}, 16'h0001);
		rd(OFS_IRQ_STAT, 16'h0001);
		wr(OFS_IRQ_EN, 16'h0000);
		cyc_wait(2);
		check({15'h0, irq}, 16'h0000);
		wr(OFS_IRQ_EN, 16'h0001);
		wr(OFS_IRQ_CLR, 16'h0001);
		cyc_wait(2);
		check({15'h0, irq}, 16'h0000);
		rd(OFS_IRQ_STAT, 16'h0000);
		rd(OFS_IRQ_CLR, 16'h0000);
		done("rollover");
		c = '{oe: 1'b0, res: 3'h0, edge_sel: 2'h0, mode: CAW_PWM};
		wr(OFS_CH_BASE, 16'(c));
		cyc_wait(2);
		check({10'h0, l_oe}, 16'h0000);
		wr(OFS_CTRL, 16'h0001);
		for (int r = 0; r < 4; r++) begin
			c = '{oe: 1'b1, res: 3'(r), edge_sel: 2'h0, mode: CAW_PWM};
			wr(8'(OFS_CH_BASE + 1), 16'h0001 << (7 + r));
			wr(OFS_CH_BASE, 16'(c));
			cyc_wait(4);
			check({10'h0, l_oe}, 16'h0001);
			hi = 16'h0000;
			repeat (1 << (8 + r)) begin
				@(negedge clk);
				hi = hi + 16'(pin[0]);
			end
			check(hi, 16'h0001 << (7 + r));
		end
		check({15'h0, wd_req}, 16'h0000);
		done("pwm");
		wr(OFS_CH_BASE, 16'h0000);
		// hso and software timer share one match point; the timebase runs a few cycles from v-3 and is then stopped, so exactly one match occurs
		wr(OFS_CTRL, 16'h0000);
		wr(OFS_IRQ_CLR, 16'h007F);
		v = 16'($urandom) & 16'h7FFF;
		wr(OFS_COUNT, v - 16'h0003);
		wr(8'(OFS_CH_BASE + 3), v);
		wr(8'(OFS_CH_BASE + 7), v);
		c = '{oe: 1'b1, res: 3'h0, edge_sel: 2'h0, mode: CAW_HSO};
		wr(8'(OFS_CH_BASE + 2), 16'(c));
		c = '{oe: 1'b0, res: 3'h0, edge_sel: 2'h0, mode: CAW_SWTMR};
		wr(8'(OFS_CH_BASE + 6), 16'(c));
		wr(OFS_CTRL, 16'h0001);
		cyc_wait(12);
		wr(OFS_CTRL, 16'h0000);
		cyc_wait(2);
		check({15'h0, pin[1]}, 16'h0001);
		rd(OFS_IRQ_STAT, 16'h0014);
		wr(8'(OFS_CH_BASE + 2), 16'h0000);
		wr(8'(OFS_CH_BASE + 6), 16'h0000);
		// frequency output: half period of 4 ticks, so any 64-cycle window is half high
		wr(8'(OFS_CH_BASE + 5), 16'h0400);
		c = '{oe: 1'b1, res: 3'h0, edge_sel: 2'h0, mode: CAW_FREQ};
		wr(8'(OFS_CH_BASE + 4), 16'(c));
		wr(OFS_CTRL, 16'h0001);
		cyc_wait(300);
		hi = 16'h0000;
		repeat (64) begin
			@(negedge clk);
			hi = hi + 16'(pin[2]);
		end
		check(hi, 16'h0020);
		wr(8'(OFS_CH_BASE + 4), 16'h0000);
		done("compare modes");
		wr(OFS_WD_CTRL, 16'h0001);
		cyc_wait(200);
		wr(OFS_WD_RESTART, 16'h0000);
		cyc_wait(200);
		check({15'h0, wd_req}, 16'h0000);
		cyc_wait(100);
		check({15'h0, wd_req}, 16'h0001);
		check({14'h0, rp_oe, rp_out}, 16'h0001);
		arst_n <= 1'b0;
		cyc_wait(4);
		arst_n <= 1'b1;
		check({15'h0, wd_req}, 16'h0000);
		rd(OFS_WD_CTRL, WD_CTRL_RST);
		done("supervisory");
		cyc_wait(3);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
